// >>> core/sbcip_pulser.v
// Event interrupt pulser: source gating, pulse timing, config-select sampling
// Functional notes
// - In Normal and Stop, drive line low for 100 us per interrupt.
// - Keep line high at least 100 us between two pulses.
// - Raising an interrupt never changes the operating mode.
// - Class select 0 (default): only enabled wake status events interrupt.
// - A wake event interrupts only if its source is wake-enabled, incl. HV pins.
// - Bus timeout is a wake source governed only by its own mask.
// - Class select 1 adds other failures; pin level status never interrupts.
// - Restart/fail-safe causes, power-on and device status never interrupt.
// - Entering Stop with wake status bits still set raises an interrupt.
// - Visible event status registers update at each falling edge of the pulse; pin level status every clock.
// - Latched events stay until host read-and-clear; level status not latched.
// - In Init mode the pin level selects hardware configuration.
// - Config-select level is filtered for 10 us before it is taken.
`timescale 1ns/1ps
`include "sbcip_defines.vh"
module sbcip_pulser
#(
	parameter WA   = 8,
	parameter WB   = 8,
	parameter WF   = 16,
	parameter WL   = 8,
	parameter TW   = 12
)
(
	clk,
	rst,
	mode,
	class_select_bit,
	bus_timeout_mask,
	wake_event_a,
	wake_event_b,
	wake_enable_a,
	wake_enable_b,
	hv_pin_wake,
	can_timeout_event,
	fail_event,
	fail_int_enable,
	pin_level_in,
	clr_a,
	clr_b,
	clr_fail,
	clr_can_timeout,
	int_pin_in,
	event_pulse_n,
	event_pulse_oe,
	wake_status_a,
	wake_status_b,
	fail_status,
	can_timeout_flag,
	pin_level_status,
	hw_config_sel,
	hw_config_valid
);
	input  wire                    clk;
	input  wire                    rst;
	input  wire [`SBCIP_MODE_W-1:0] mode;
	input  wire                    class_select_bit;
	input  wire                    bus_timeout_mask;
	input  wire [WA-1:0]           wake_event_a;
	input  wire [WB-1:0]           wake_event_b;
	input  wire [WA-1:0]           wake_enable_a;
	input  wire [WB-1:0]           wake_enable_b;
	input  wire [WB-1:0]           hv_pin_wake;
	input  wire                    can_timeout_event;
	input  wire [WF-1:0]           fail_event;
	input  wire [WF-1:0]           fail_int_enable;
	input  wire [WL-1:0]           pin_level_in;
	input  wire                    clr_a;
	input  wire                    clr_b;
	input  wire                    clr_fail;
	input  wire                    clr_can_timeout;
	input  wire                    int_pin_in;
	output wire                    event_pulse_n;
	output wire                    event_pulse_oe;
	output reg  [WA-1:0]           wake_status_a;
	output reg  [WB-1:0]           wake_status_b;
	output reg  [WF-1:0]           fail_status;
	output reg                     can_timeout_flag;
	output reg  [WL-1:0]           pin_level_status;
	output reg                     hw_config_sel;
	output reg                     hw_config_valid;

	// ****************************************
	// Internal latches (hidden until pulse edge)
	// ****************************************
	reg [WA-1:0]  lat_a_q;
	reg [WB-1:0]  lat_b_q;
	reg [WF-1:0]  lat_f_q;
	reg           lat_c_q;
	reg [1:0]     state_q;
	reg [1:0]     state_d;
	reg           pend_q;
	reg           pend_d;
	reg [`SBCIP_MODE_W-1:0] mode_q;
	reg [TW-1:0]  cfg_cnt_q;
	reg           cfg_lvl_q;

	wire [WB-1:0] en_b;
	wire [WA-1:0] new_a;
	wire [WB-1:0] new_b;
	wire [WF-1:0] new_f;
	wire          new_c;
	wire          int_mode;
	wire          stop_entry;
	wire          trig;
	wire          tmr_exp;
	reg           tmr_load;
	reg  [TW-1:0] tmr_val;
	wire          pin_s;
	wire          fall;

	// ****************************************
	// Timer load values, cut to the counter width on purpose
	// ****************************************
	localparam integer PULSE_LD = `SBCIP_PULSE_CYC;
	localparam integer GAP_LD   = `SBCIP_GAP_CYC;
	localparam integer FILT_LD  = `SBCIP_CFG_FILT_CYC;

	// ****************************************
	// Event qualification
	// ****************************************
	assign en_b  = wake_enable_b | hv_pin_wake;
	assign new_a = wake_event_a & wake_enable_a & ~lat_a_q;
	assign new_b = wake_event_b & en_b & ~lat_b_q;
	assign new_c = can_timeout_event & ~lat_c_q;
	// Fail sources exclude restart/fail-safe causes via fail_int_enable wiring
	assign new_f = fail_event & fail_int_enable & ~lat_f_q;
	assign int_mode = (mode == `SBCIP_MODE_NORMAL) || (mode == `SBCIP_MODE_STOP);
	assign stop_entry = (mode == `SBCIP_MODE_STOP) && (mode_q != `SBCIP_MODE_STOP)
		&& ((|lat_a_q) || (|lat_b_q));
	assign trig = int_mode && ((|new_a) || (|new_b)
		|| (new_c && !bus_timeout_mask)
		|| (class_select_bit && (|new_f))
		|| stop_entry);
	// Mode is an input only: nothing here drives it back

	// ****************************************
	// Event latches: set wins over clear
	// ****************************************
	always @(posedge clk)
	begin
		if (rst)
		begin
			lat_a_q <= {WA{1'b0}};
			lat_b_q <= {WB{1'b0}};
			lat_f_q <= {WF{1'b0}};
			lat_c_q <= 1'b0;
			mode_q  <= `SBCIP_MODE_INIT;
		end
		else
		begin
			mode_q  <= mode;
			lat_a_q <= (clr_a ? {WA{1'b0}} : lat_a_q) | (wake_event_a & wake_enable_a);
			lat_b_q <= (clr_b ? {WB{1'b0}} : lat_b_q) | (wake_event_b & en_b);
			lat_f_q <= (clr_fail ? {WF{1'b0}} : lat_f_q) | fail_event;
			lat_c_q <= (clr_can_timeout ? 1'b0 : lat_c_q) | can_timeout_event;
		end
	end

	// ****************************************
	// Pulse state machine
	// ****************************************
	always @*
	begin
		state_d  = state_q;
		pend_d   = pend_q | trig;
		tmr_load = 1'b0;
		tmr_val  = {TW{1'b0}};
		case (state_q)
			`SBCIP_ST_IDLE:
			begin
				// Pending pulses wait for Normal or Stop
				if (pend_d && int_mode)
				begin
					state_d  = `SBCIP_ST_LOW;
					pend_d   = 1'b0;
					tmr_load = 1'b1;
					tmr_val  = PULSE_LD[TW-1:0];
				end
			end
			`SBCIP_ST_LOW:
			begin
				if (tmr_exp)
				begin
					state_d  = `SBCIP_ST_GAP;
					tmr_load = 1'b1;
					tmr_val  = GAP_LD[TW-1:0];
				end
			end
			`SBCIP_ST_GAP:
			begin
				if (tmr_exp)
					state_d = `SBCIP_ST_IDLE;
			end
			default:
				state_d = `SBCIP_ST_IDLE;
		endcase
	end

	assign fall = (state_q == `SBCIP_ST_IDLE) && (state_d == `SBCIP_ST_LOW);

	always @(posedge clk)
	begin
		if (rst)
		begin
			state_q <= `SBCIP_ST_IDLE;
			pend_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			pend_q  <= pend_d;
		end
	end

	sbcip_timer #(.W(TW)) u_tmr
	(
		.clk      (clk),
		.rst      (rst),
		.load     (tmr_load),
		.load_val (tmr_val),
		.expired  (tmr_exp)
	);

	// Timer counts down one extra cycle after load, so low time is N+1 cycles,
	// which stays inside the 80..120 us window
	assign event_pulse_n  = (state_q != `SBCIP_ST_LOW);
	// Released in Init so the external strap sets the level
	assign event_pulse_oe = (mode != `SBCIP_MODE_INIT);

	// ****************************************
	// Visible status: event flags copied at falling edge, cleared by host; pin level copied every clock
	// ****************************************
	always @(posedge clk)
	begin
		if (rst)
		begin
			wake_status_a    <= {WA{1'b0}};
			wake_status_b    <= {WB{1'b0}};
			fail_status      <= {WF{1'b0}};
			can_timeout_flag <= 1'b0;
			pin_level_status <= {WL{1'b0}};
		end
		else
		begin
			pin_level_status <= pin_level_in;
			if (fall)
			begin
				wake_status_a    <= lat_a_q | new_a;
				wake_status_b    <= lat_b_q | new_b;
				fail_status      <= lat_f_q | new_f;
				can_timeout_flag <= lat_c_q | new_c;
			end
			else
			begin
				if (clr_a)
					wake_status_a <= {WA{1'b0}};
				if (clr_b)
					wake_status_b <= {WB{1'b0}};
				if (clr_fail)
					fail_status <= {WF{1'b0}};
				if (clr_can_timeout)
					can_timeout_flag <= 1'b0;
			end
		end
	end

	// ****************************************
	// Configuration select in Init
	// ****************************************
	sbcip_sync u_sync
	(
		.clk      (clk),
		.rst      (rst),
		.async_in (int_pin_in),
		.sync_out (pin_s)
	);

	always @(posedge clk)
	begin
		if (rst)
		begin
			cfg_cnt_q       <= {TW{1'b0}};
			cfg_lvl_q       <= 1'b0;
			hw_config_sel   <= 1'b0;
			hw_config_valid <= 1'b0;
		end
		else if (mode == `SBCIP_MODE_INIT)
		begin
			cfg_lvl_q <= pin_s;
			if (pin_s != cfg_lvl_q)
				cfg_cnt_q <= {TW{1'b0}};
			else if (cfg_cnt_q != FILT_LD[TW-1:0])
				cfg_cnt_q <= cfg_cnt_q + {{(TW-1){1'b0}}, 1'b1};
			else
			begin
				hw_config_sel   <= cfg_lvl_q;
				hw_config_valid <= 1'b1;
			end
		end
	end
endmodule

// >>> core/sbcip_defines.vh
// Timing and mode constants for the event interrupt pulser
`ifndef SBCIP_DEFINES_VH
`define SBCIP_DEFINES_VH

// ****************************************
// Clock and timing
// ****************************************
`define SBCIP_CLK_MHZ          20
`define SBCIP_PULSE_US         100
`define SBCIP_GAP_US           100
`define SBCIP_CFG_FILT_US      10
`define SBCIP_PULSE_CYC        (`SBCIP_PULSE_US * `SBCIP_CLK_MHZ)
`define SBCIP_GAP_CYC          (`SBCIP_GAP_US * `SBCIP_CLK_MHZ)
`define SBCIP_CFG_FILT_CYC     (`SBCIP_CFG_FILT_US * `SBCIP_CLK_MHZ)

// ****************************************
// Operating modes
// ****************************************
`define SBCIP_MODE_W           3
`define SBCIP_MODE_INIT        3'h0
`define SBCIP_MODE_NORMAL      3'h1
`define SBCIP_MODE_STOP        3'h2
`define SBCIP_MODE_SLEEP       3'h3
`define SBCIP_MODE_RESTART     3'h4
`define SBCIP_MODE_FAILSAFE    3'h5

// ****************************************
// Pulser states
// ****************************************
`define SBCIP_ST_IDLE          2'h0
`define SBCIP_ST_LOW           2'h1
`define SBCIP_ST_GAP           2'h2

`endif

// >>> core/sbcip_sync.v
// Two-flop synchroniser for an asynchronous level
`timescale 1ns/1ps
module sbcip_sync
(
	clk,
	rst,
	async_in,
	sync_out
);
	input  wire clk;
	input  wire rst;
	input  wire async_in;
	output wire sync_out;

	reg         meta_q;
	reg         sync_q;

	// First stage feeds only the second stage
	always @(posedge clk)
	begin
		if (rst)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end
		else
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

	assign sync_out = sync_q;
endmodule

// >>> core/sbcip_timer.v
// Load-and-count-down timer, flags expiry as a level
`timescale 1ns/1ps
module sbcip_timer
#(
	parameter W = 12
)
(
	clk,
	rst,
	load,
	load_val,
	expired
);
	input  wire         clk;
	input  wire         rst;
	input  wire         load;
	input  wire [W-1:0] load_val;
	output wire         expired;

	reg [W-1:0]         cnt_q;

	always @(posedge clk)
	begin
		if (rst)
			cnt_q <= {W{1'b0}};
		else if (load)
			cnt_q <= load_val;
		else if (cnt_q != {W{1'b0}})
			cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
	end

	assign expired = (cnt_q == {W{1'b0}});
endmodule

// >>> tb/sbcip_pulser_sva.sv
// Checker for the event interrupt pulser
`timescale 1ns/1ps
`include "sbcip_defines.vh"
module sbcip_pulser_sva
(
	input wire logic                     clk,
	input wire logic                     rst,
	input wire logic [`SBCIP_MODE_W-1:0] mode,
	input wire logic                     clr_a,
	input wire logic [7:0]               wake_status_a,
	input wire logic                     event_pulse_n,
	input wire logic                     event_pulse_oe,
	input wire logic                     hw_config_valid
);
	logic [11:0] lo_q;
	logic [11:0] hi_q;
	logic [7:0]  init_q;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// ****************************************
	// Run lengths; high run starts full so a first pulse is legal
	// ****************************************
	always @(posedge clk)
	begin
		lo_q <= (rst || event_pulse_n) ? 12'h0 : lo_q + 12'h1;
		hi_q <= (rst) ? 12'hfff : (!event_pulse_n) ? 12'h0 : hi_q + {11'h0, hi_q != 12'hfff};
		init_q <= (rst || mode != `SBCIP_MODE_INIT) ? 8'h0 : init_q + {7'h0, init_q != 8'hff};
	end
	// ****************************************
	// Properties
	// ****************************************
	chk_pulse_width: assert property ($rose(event_pulse_n) |-> lo_q == 12'd2001)
		else $error("pulse width off");
	chk_gap_width: assert property ($fell(event_pulse_n) |-> hi_q >= 12'd2001)
		else $error("gap too short");
	chk_pulse_mode: assert property ($fell(event_pulse_n) |->
		$past(mode) == `SBCIP_MODE_NORMAL || $past(mode) == `SBCIP_MODE_STOP)
		else $error("pulse outside normal or stop");
	chk_init_release: assert property (mode == `SBCIP_MODE_INIT |-> !event_pulse_oe)
		else $error("pin driven in init");
	chk_set_at_fall: assert property ((wake_status_a & ~$past(wake_status_a)) != 8'h0
		|-> $fell(event_pulse_n)) else $error("status set off the falling edge");
	chk_drop_by_clr: assert property (($past(wake_status_a) & ~wake_status_a) != 8'h0
		|-> $past(clr_a)) else $error("status dropped without clear");
	chk_stop_entry: assert property (mode == `SBCIP_MODE_STOP && $past(mode) != mode
		&& wake_status_a != 8'h0 && hi_q > 12'd2100 |=> !event_pulse_n)
		else $error("no pulse on stop entry");
	chk_cfg_filter: assert property ($rose(hw_config_valid) |-> init_q >= 8'd200)
		else $error("config taken before filter time");
	chk_cfg_sticky: assert property (hw_config_valid |=> hw_config_valid)
		else $error("config valid lost");
	cov_pulse: cover property ($fell(event_pulse_n));
	cov_stop: cover property (mode == `SBCIP_MODE_STOP && $past(mode) != mode);
	cov_cfg: cover property ($rose(hw_config_valid));
endmodule
bind sbcip_pulser sbcip_pulser_sva u_sva (.clk(clk), .rst(rst), .mode(mode), .clr_a(clr_a),
	.wake_status_a(wake_status_a), .event_pulse_n(event_pulse_n),
	.event_pulse_oe(event_pulse_oe), .hw_config_valid(hw_config_valid));

// >>> tb/sbcip_host_model.sv
// Host side model: shared pin level and pulse counter
`timescale 1ns/1ps
module sbcip_host_model
(
	input wire logic clk,
	input wire logic event_pulse_n,
	input wire logic event_pulse_oe,
	input wire logic strap_level,
	output logic     int_pin_in,
	output int       pulse_cnt
);
	logic prev_q = 1'b1;
	int   cnt_q  = 0;
	// Released pin shows the board strap, else the driven level
	assign int_pin_in = event_pulse_oe ? event_pulse_n : strap_level;
	assign pulse_cnt  = cnt_q;
	always @(posedge clk)
	begin
		prev_q <= event_pulse_n;
		if (prev_q && !event_pulse_n)
			cnt_q <= cnt_q + 1;
	end
endmodule

// >>> tb/tb_sbc_event_interrupt_pulser.sv
// Self-checking bench for the event interrupt pulser
`timescale 1ns/1ps
module tb_sbc_event_interrupt_pulser;
	logic        clk, rst, cls, mask, can_ev, strap, pin, pn, oe, can_f, sel, vld;
	logic        clr_a, clr_b, clr_f, clr_c;
	logic [2:0]  mode;
	logic [7:0]  ev_a, ev_b, en_a, en_b, hv, lvl, st_a, st_b, lvl_st;
	logic [15:0] fail_ev, fail_en, st_f;
	int          pulses, err_total, check_count;
	sbcip_pulser dut (.clk(clk), .rst(rst), .mode(mode), .class_select_bit(cls),
		.bus_timeout_mask(mask), .wake_event_a(ev_a), .wake_event_b(ev_b),
		.wake_enable_a(en_a), .wake_enable_b(en_b), .hv_pin_wake(hv),
		.can_timeout_event(can_ev), .fail_event(fail_ev), .fail_int_enable(fail_en),
		.pin_level_in(lvl), .clr_a(clr_a), .clr_b(clr_b), .clr_fail(clr_f),
		.clr_can_timeout(clr_c), .int_pin_in(pin), .event_pulse_n(pn), .event_pulse_oe(oe),
		.wake_status_a(st_a), .wake_status_b(st_b), .fail_status(st_f),
		.can_timeout_flag(can_f), .pin_level_status(lvl_st), .hw_config_sel(sel),
		.hw_config_valid(vld));
	sbcip_host_model host (.clk(clk), .event_pulse_n(pn), .event_pulse_oe(oe),
		.strap_level(strap), .int_pin_in(pin), .pulse_cnt(pulses));
	// ****************************************
	// Shared tasks
	// ****************************************
	task end_sim;
	begin
		if (err_total == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
	begin
		check_count++;
		if (g !== e)
		begin
			err_total++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	end
	endtask
	task ev(input logic [7:0] a, input logic [7:0] b, input logic c, input logic [15:0] f);
	begin
		@(posedge clk);
		{ev_a, ev_b, can_ev, fail_ev} <= {a, b, c, f};
		@(posedge clk);
		{ev_a, ev_b, can_ev, fail_ev} <= 33'h0;
	end
	endtask
	task clr(input logic [3:0] m);
	begin
		@(posedge clk);
		{clr_c, clr_f, clr_b, clr_a} <= m;
		@(posedge clk);
		{clr_c, clr_f, clr_b, clr_a} <= 4'h0;
		@(negedge clk);
	end
	endtask
	task quiet(input int n);
		logic ok;
	begin
		ok = 1'b1;
		repeat (n)
		begin
			@(negedge clk);
			ok &= (pn === 1'b1);
		end
		chk("quiet", 16'h1, {15'h0, ok});
	end
	endtask
	// Waits for a pulse, measures it, then sits out the gap
	task pulse;
		int n;
	begin
		n = 0;
		while (pn !== 1'b0)
		begin
			@(negedge clk);
			n++;
			if (n > 4200)
			begin
				err_total++;
				end_sim;
			end
		end
		n = 0;
		while (pn === 1'b0 && n < 2100)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 2100)
		begin
			err_total++;
			end_sim;
		end
		chk("width", 16'd2001, n[15:0]);
		quiet(2000);
	end
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task t_cfg;
		int n;
	begin
		n = 0;
		while (vld !== 1'b1 && n < 400)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 400)
		begin
			err_total++;
			end_sim;
		end
		chk("cfg_vld", 16'h1, {15'h0, vld});
		chk("cfg_sel", 16'h1, {15'h0, sel});
		chk("oe_init", 16'h0, {15'h0, oe});
	end
	endtask
	task t_wake;
	begin
		@(posedge clk);
		mode <= 3'h1;
		fork
			begin
				repeat (100) @(posedge clk);
				ev(8'h02, 8'h0, 1'b0, 16'h0);
			end
		join_none
		ev(8'h01, 8'h0, 1'b0, 16'h0);
		pulse;
		chk("st_a_first", 16'h01, {8'h0, st_a});
		chk("oe_run", 16'h1, {15'h0, oe});
		pulse;
		chk("st_a_merged", 16'h03, {8'h0, st_a});
		chk("pulses", 16'd2, pulses[15:0]);
		clr(4'h1);
		chk("st_a_clr", 16'h0, {8'h0, st_a});
		@(negedge clk);
		chk("st_a_reread", 16'h0, {8'h0, st_a});
	end
	endtask
	task t_block;
	begin
		@(posedge clk);
		cls <= 1'b1;
		mask <= 1'b1;
		lvl <= 8'h5a;
		ev(8'h04, 8'h02, 1'b1, 16'h8000);
		quiet(300);
		chk("lvl", 16'h5a, {8'h0, lvl_st});
		@(posedge clk);
		cls <= 1'b0;
		ev(8'h0, 8'h0, 1'b0, 16'h0001);
		quiet(300);
		clr(4'hf);
		@(posedge clk);
		cls <= 1'b1;
		ev(8'h0, 8'h0, 1'b0, 16'h0002);
		pulse;
		chk("st_f", 16'h0002, st_f);
		@(posedge clk);
		cls <= 1'b0;
		mask <= 1'b0;
		ev(8'h0, 8'h0, 1'b1, 16'h0);
		pulse;
		chk("can_f", 16'h1, {15'h0, can_f});
		@(posedge clk);
		hv <= 8'h01;
		ev(8'h0, 8'h01, 1'b0, 16'h0);
		pulse;
		chk("st_b", 16'h01, {8'h0, st_b});
		clr(4'hf);
	end
	endtask
	task t_stop;
	begin
		ev(8'h01, 8'h0, 1'b0, 16'h0);
		pulse;
		quiet(200);
		@(posedge clk);
		mode <= 3'h2;
		pulse;
		chk("st_a_stop", 16'h01, {8'h0, st_a});
	end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		{rst, strap, cls, mask, can_ev, clr_a, clr_b, clr_f, clr_c} = 9'h180;
		{mode, ev_a, ev_b, en_b, hv, lvl, fail_ev} = 59'h0;
		en_a = 8'h03;
		fail_en = 16'h00ff;
		{err_total, check_count} = 64'h0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_cfg;
		t_wake;
		t_block;
		t_stop;
		end_sim;
	end
endmodule
